// ==== hw/ddrf_regs.vh ====
// ddrf_regs.vh: constants for the x16 ddr command/address framing slave.
// assumes inclusion by bare name from the ddrf design files.
`ifndef DDRF_REGS_VH
`define DDRF_REGS_VH

`define DDRF_CA_WIDTH 48
`define DDRF_CA_EDGES 6
`define DDRF_BIT_DIR 47
`define DDRF_BIT_SPACE 46
`define DDRF_BIT_BURST 45
`define DDRF_ROW_HI 44
`define DDRF_ROW_LO 16
`define DDRF_RSV_HI 15
`define DDRF_RSV_LO 3
`define DDRF_COL_HI 2
`define DDRF_COL_LO 0
`define DDRF_HALF_PAGE_WORDS 8
`define DDRF_DIR_READ 1'b1
`define DDRF_SPACE_MEM 1'b0
`define DDRF_BURST_LINEAR 1'b1
`define DDRF_DEFAULT_ADDR_W 10

`endif

// ==== hw/ddrf_slave.v ====
// ddrf_slave.v: device side of a 16-bit ddr command/address framing link.
// assumes bus_clock at most about a quarter of sys_clk, sampled as a plain input;
// the data ports of the far end settle a sys_clk before each bus_clock edge.
`timescale 1ns/1ps
`include "ddrf_regs.vh"

// How it works
// - three command/address words open every transaction
// - ca bytes on low lanes, msb first
// - ca sampled at centre, on clock edges
// - bit 47 picks read or write
// - bit 46 picks memory or register space
// - bit 45 picks wrapped or linear burst
// - bits 44..16 give upper word address
// - bits 15..3 reserved, ignored here
// - bits 2..0 give starting word
// - upper field picks eight-word half-page
// - read access starts once row captured
// - data always moves as whole words
// - read data edge-aligned with strobes
// - one word per clock edge, advancing
// - data bit n on lane n
// - strobe 0 masks low byte, 1 high
// - zero-latency writes ignore strobes, unmasked
// - read returns data as written
// - masked word leaves array unchanged
// - strobes high during ca requests latency
// - select rising ends transaction
module ddrf_slave
#(
  parameter ADDR_W = `DDRF_DEFAULT_ADDR_W,
  parameter LATENCY_EDGES = 8,
  parameter EXTRA_LATENCY = 0
)
(
  input wire sys_clk,
  input wire reset_n,
  input wire select_n,
  input wire bus_clock,
  input wire bus_clock_complement,
  input wire [15:0] dq_in,
  output reg [15:0] dq_out,
  output reg dq_oe,
  input wire [1:0] strobe_mask_lanes_in,
  output reg [1:0] strobe_mask_lanes_out,
  output reg strobe_mask_lanes_oe,
  input wire zero_latency_write,
  output reg busy,
  output reg is_read,
  output reg is_register_space,
  output reg is_linear,
  output reg [28:0] word_addr_hi,
  output reg [2:0] start_word,
  output reg ca_done,
  output reg framing_error
);

localparam ST_IDLE = 3'd0;
localparam ST_CA = 3'd1;
localparam ST_LAT = 3'd2;
localparam ST_DATA = 3'd3;
localparam ST_WAIT_END = 3'd4;

localparam AW = (ADDR_W < 3) ? 3 : ADDR_W;

wire sel_n_s;
wire clk_s;
wire clkn_s;
wire [15:0] dq_s;
wire [1:0] rwds_s;

ddrf_sync2 u_sync_sel
(
  .sys_clk(sys_clk),
  .reset_n(reset_n),
  // inverted pin: reset level 0 means deselected
  .reset_val(1'b0),
  .pin_in(~select_n),
  .sync_out(sel_n_s)
);

ddrf_sync2 u_sync_clk
(
  .sys_clk(sys_clk),
  .reset_n(reset_n),
  .reset_val(1'b0),
  .pin_in(bus_clock),
  .sync_out(clk_s)
);

ddrf_sync2 u_sync_clkn
(
  .sys_clk(sys_clk),
  .reset_n(reset_n),
  .reset_val(1'b1),
  .pin_in(bus_clock_complement),
  .sync_out(clkn_s)
);

genvar gi;
generate
  for (gi = 0; gi < 16; gi = gi + 1)
  begin : g_dq
    ddrf_sync2 u_sync_dq
    (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .reset_val(1'b0),
      .pin_in(dq_in[gi]),
      .sync_out(dq_s[gi])
    );
  end
  for (gi = 0; gi < 2; gi = gi + 1)
  begin : g_rwds
    ddrf_sync2 u_sync_rwds
    (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .reset_val(1'b0),
      .pin_in(strobe_mask_lanes_in[gi]),
      .sync_out(rwds_s[gi])
    );
  end
endgenerate

// select synchroniser carries the inverted pin so reset leaves it deselected
wire sel_active = sel_n_s;

// edge detectors reset to the synchronisers' reset levels: no false edge
reg clk_d;
reg sel_d;
reg [2:0] state;
reg [2:0] edge_cnt;
reg [7:0] lat_cnt;
reg [`DDRF_CA_WIDTH-1:0] ca_shift;
reg [AW-1:0] cur_addr;
reg [AW-1:0] base_addr;
reg [15:0] mem [0:(1<<AW)-1];
reg rd_pending;
reg [15:0] rd_word;

// either polarity of bus_clock is one ddr edge
wire clk_edge = clk_s ^ clk_d;
wire sel_fall = sel_active & ~sel_d;
wire sel_rise = ~sel_active & sel_d;
wire clk_idle = ~clk_s & clkn_s;

// next word address: wrapped bursts stay in the eight-word half-page
wire [AW-1:0] lin_next = cur_addr + {{(AW-1){1'b0}}, 1'b1};
wire [AW-1:0] wrap_next = {base_addr[AW-1:3], lin_next[2:0]};
wire [AW-1:0] next_addr = is_linear ? lin_next : wrap_next;

// address of the word seen after this ca edge, from captured fields
wire [`DDRF_CA_WIDTH-1:0] ca_full = {ca_shift[`DDRF_CA_WIDTH-9:0], dq_s[7:0]};
wire [31:0] ca_word_addr = {ca_full[`DDRF_ROW_HI:`DDRF_ROW_LO], ca_full[`DDRF_COL_HI:`DDRF_COL_LO]};
// after four edges the row/half-page bits sit in the low 29 bits of ca_full
wire [31:0] ca_early_addr = {ca_full[28:0], 3'h0};

always @(posedge sys_clk)
begin
  if (!reset_n)
  begin
    clk_d <= 1'b0;
    sel_d <= 1'b0;
  end
  else
  begin
    clk_d <= clk_s;
    sel_d <= sel_active;
  end
end

// memory array: writes only in memory space, honouring byte masks
// zero-latency writes have no mask phase, so strobes are ignored there
always @(posedge sys_clk)
begin
  if (state == ST_DATA && clk_edge && !is_read && !is_register_space)
  begin
    if (zero_latency_write || !rwds_s[0])
      mem[cur_addr][7:0] <= dq_s[7:0];
    if (zero_latency_write || !rwds_s[1])
      mem[cur_addr][15:8] <= dq_s[15:8];
  end
end

// read fetch starts as soon as row/half-page is known, before the start word, and again once the start word is in
always @(posedge sys_clk)
begin
  if (!reset_n)
    rd_word <= 16'h0000;
  else if (rd_pending)
    rd_word <= mem[cur_addr];
end

// frame sequencer: select edges, ca capture, latency count, data phase
always @(posedge sys_clk)
begin
  if (!reset_n)
  begin
    state <= ST_IDLE;
    edge_cnt <= 3'd0;
    lat_cnt <= 8'h00;
    ca_shift <= 48'h000000000000;
    cur_addr <= {AW{1'b0}};
    base_addr <= {AW{1'b0}};
    rd_pending <= 1'b0;
    dq_out <= 16'h0000;
    dq_oe <= 1'b0;
    strobe_mask_lanes_out <= 2'h0;
    strobe_mask_lanes_oe <= 1'b0;
    busy <= 1'b0;
    is_read <= 1'b0;
    is_register_space <= 1'b0;
    is_linear <= 1'b0;
    word_addr_hi <= 29'h00000000;
    start_word <= 3'h0;
    ca_done <= 1'b0;
    framing_error <= 1'b0;
  end
  else
  begin
    ca_done <= 1'b0;
    rd_pending <= 1'b0;
    if (sel_rise && state != ST_IDLE)
    begin
      state <= ST_IDLE;
      busy <= 1'b0;
      dq_oe <= 1'b0;
      strobe_mask_lanes_oe <= 1'b0;
      if (state == ST_CA)
        framing_error <= 1'b1;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (sel_fall)
          begin
            framing_error <= !clk_idle;
            busy <= 1'b1;
            edge_cnt <= 3'd0;
            if (clk_idle)
            begin
              state <= ST_CA;
              // latency request shown on strobes while ca words arrive
              strobe_mask_lanes_out <= EXTRA_LATENCY ? 2'h3 : 2'h0;
              strobe_mask_lanes_oe <= 1'b1;
            end
            else
            begin
              // clock already running: ca alignment unknown, so ignore the frame
              state <= ST_WAIT_END;
            end
          end
        end
        ST_CA:
        begin
          if (clk_edge)
          begin
            // each edge takes one byte from lanes 7..0, msb byte first; upper lanes unused
            ca_shift <= ca_full;
            edge_cnt <= edge_cnt + 3'd1;
            if (edge_cnt == 3'd3)
            begin
              // row and half-page captured: open array access early
              cur_addr <= ca_early_addr[AW-1:0];
              rd_pending <= 1'b1;
            end
            if (edge_cnt == `DDRF_CA_EDGES - 1)
            begin
              is_read <= ca_full[`DDRF_BIT_DIR] == `DDRF_DIR_READ;
              is_register_space <= ca_full[`DDRF_BIT_SPACE] != `DDRF_SPACE_MEM;
              is_linear <= ca_full[`DDRF_BIT_BURST] == `DDRF_BURST_LINEAR;
              word_addr_hi <= ca_full[`DDRF_ROW_HI:`DDRF_ROW_LO];
              // reserved bits 15..3 deliberately not looked at
              start_word <= ca_full[`DDRF_COL_HI:`DDRF_COL_LO];
              cur_addr <= ca_word_addr[AW-1:0];
              base_addr <= ca_word_addr[AW-1:0];
              ca_done <= 1'b1;
              rd_pending <= 1'b1;
              strobe_mask_lanes_oe <= 1'b0;
              strobe_mask_lanes_out <= 2'h0;
              lat_cnt <= 8'h00;
              if (!ca_full[`DDRF_BIT_DIR] && zero_latency_write)
                state <= ST_DATA;
              else
                state <= ST_LAT;
            end
          end
        end
        ST_LAT:
        begin
          if (clk_edge)
          begin
            lat_cnt <= lat_cnt + 8'h01;
            if (lat_cnt == LATENCY_EDGES * (EXTRA_LATENCY ? 2 : 1) - 1)
            begin
              state <= ST_DATA;
              if (is_read)
              begin
                // launch first word with first strobe rise, edge aligned
                dq_out <= rd_word;
                dq_oe <= 1'b1;
                strobe_mask_lanes_out <= 2'h3;
                strobe_mask_lanes_oe <= 1'b1;
                cur_addr <= next_addr;
                rd_pending <= 1'b1;
              end
            end
          end
        end
        ST_DATA:
        begin
          if (clk_edge)
          begin
            cur_addr <= next_addr;
            rd_pending <= 1'b1;
            if (is_read)
            begin
              // strobe toggles with each word, data changes with it
              dq_out <= rd_word;
              strobe_mask_lanes_out <= ~strobe_mask_lanes_out;
            end
          end
        end
        // refused frame: only the select rise above leaves this state
        ST_WAIT_END:
          state <= ST_WAIT_END;
        default:
          state <= ST_IDLE;
      endcase
    end
  end
end

endmodule // ddrf_slave

// ==== hw/ddrf_sync2.v ====
// ddrf_sync2.v: two-flop synchroniser for one pin level.
// assumes the input is asynchronous to sys_clk.
`timescale 1ns/1ps

module ddrf_sync2
(
  input wire sys_clk,
  input wire reset_n,
  input wire reset_val,
  input wire pin_in,
  output reg sync_out
);

reg stage;

always @(posedge sys_clk)
begin
  if (!reset_n)
  begin
    stage <= reset_val;
    sync_out <= reset_val;
  end
  else
  begin
    stage <= pin_in;
    sync_out <= stage;
  end
end

endmodule // ddrf_sync2

// ==== verification/ddrf_host_model.sv ====
// ddrf_host_model.sv: behavioural host driving select, link clock and lanes.
// assumes the bench fills wd/wm and calls xact; half period 24 ns.
`timescale 1ns/1ps
module ddrf_host_model
(
  input wire [15:0] dq_out,
  input wire [1:0] strobe_mask_lanes_out,
  output reg select_n,
  output reg bus_clock,
  output reg bus_clock_complement,
  output reg [15:0] dq_in,
  output reg [1:0] strobe_mask_lanes_in
);
  reg [15:0] wd [0:7];
  reg [1:0] wm [0:7];
  reg [15:0] rd [0:7];
  reg [15:0] last;
  reg [1:0] rs [0:7];
  reg [1:0] lasts;
  initial
  begin
    select_n = 1'b1;
    bus_clock = 1'b0;
    bus_clock_complement = 1'b1;
    dq_in = 16'h0000;
    strobe_mask_lanes_in = 2'h3;
  end
  // read sample 4 ns after an edge, before the device updates;
  // lanes and masks move mid half-period so they sit settled around each edge
  task step(input [15:0] d, input [1:0] m);
  begin
    #4 last = dq_out;
    lasts = strobe_mask_lanes_out;
    #8 dq_in = d;
    strobe_mask_lanes_in = m;
    #12 bus_clock = ~bus_clock;
    bus_clock_complement = ~bus_clock;
  end
  endtask
  task xact(input [47:0] ca, input integer lat, input integer n, input rd_en);
    integer i;
  begin
    select_n = 1'b0;
    for (i = 0; i < 6; i = i + 1)
      step({8'h00, ca[47-8*i -: 8]}, 2'h3);
    for (i = 0; i < lat; i = i + 1)
      step(~dq_in, 2'h3);
    for (i = 0; i < n; i = i + 1)
    begin
      step(rd_en ? ~dq_in : wd[i], rd_en ? 2'h3 : wm[i]);
      if (i > 0)
      begin
        rd[i-1] = last;
        rs[i-1] = lasts;
      end
    end
    #4 rd[n-1] = dq_out;
    rs[n-1] = strobe_mask_lanes_out;
    #6 select_n = 1'b1;
    dq_in = ~dq_in;
    strobe_mask_lanes_in = 2'h3;
    // select must stay high long enough for the synchroniser to see it
    #24;
  end
  endtask
  task bad_start;
  begin
    bus_clock = 1'b1;
    bus_clock_complement = 1'b0;
    #24 select_n = 1'b0;
    #60 select_n = 1'b1;
    #24 bus_clock = 1'b0;
    bus_clock_complement = 1'b1;
  end
  endtask
endmodule // ddrf_host_model

// ==== verification/ddrf_slave_assertions.sv ====
// ddrf_slave_assertions.sv: port timing checks for the framing slave.
// assumes binding into ddrf_slave; pins reach its logic ~3 sys_clk late.
`timescale 1ns/1ps
module ddrf_slave_assertions
(
  input wire sys_clk,
  input wire reset_n,
  input wire select_n,
  input wire bus_clock,
  input wire dq_oe,
  input wire strobe_mask_lanes_oe,
  input wire is_read,
  input wire busy,
  input wire ca_done,
  input wire framing_error
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_start;
    $fell(select_n) && !bus_clock;
  endsequence
  sequence s_bad_start;
    $fell(select_n) && bus_clock;
  endsequence
  a_busy_rise: assert property (s_start |-> ##[2:6] busy)
    else $error("busy late");
  a_strobe_drive: assert property (s_start |-> ##[2:6] strobe_mask_lanes_oe)
    else $error("strobe not driven");
  a_busy_fall: assert property ($rose(select_n) |-> ##[2:6] !busy)
    else $error("busy stuck");
  a_ca_not_early: assert property (s_start |=> !ca_done [*8])
    else $error("ca early");
  a_ca_pulse: assert property (ca_done |=> !ca_done)
    else $error("ca pulse long");
  a_ca_in_frame: assert property (ca_done |-> busy)
    else $error("ca outside frame");
  a_read_drive: assert property (dq_oe |-> strobe_mask_lanes_oe && is_read)
    else $error("read drive");
  a_err_flag: assert property (s_bad_start |-> ##[2:6] framing_error)
    else $error("error missed");
  a_err_sticky: assert property (framing_error && select_n |=> framing_error)
    else $error("error dropped");
endmodule // ddrf_slave_assertions

bind ddrf_slave ddrf_slave_assertions i_chk
(
  .sys_clk(sys_clk),
  .reset_n(reset_n),
  .select_n(select_n),
  .bus_clock(bus_clock),
  .dq_oe(dq_oe),
  .strobe_mask_lanes_oe(strobe_mask_lanes_oe),
  .is_read(is_read),
  .busy(busy),
  .ca_done(ca_done),
  .framing_error(framing_error)
);

// ==== verification/testbench.sv ====
// testbench.sv: self-checking bench for the framing slave.
// assumes ddrf_host_model as far side; default array depth.
`timescale 1ns/1ps
module testbench;
  reg sys_clk = 1'b0;
  reg reset_n = 1'b0;
  reg zero_latency_write = 1'b0;
  wire select_n, bus_clock, bus_clock_complement, dq_oe, strobe_mask_lanes_oe, busy;
  wire is_read, is_register_space, is_linear, ca_done, framing_error;
  wire [15:0] dq_in, dq_out;
  wire [1:0] strobe_mask_lanes_in, strobe_mask_lanes_out;
  wire [28:0] word_addr_hi;
  wire [2:0] start_word;
  reg [15:0] mem [0:7];
  integer err_count = 0;
  integer n_tests = 0;
  integer dones = 0;
  localparam [28:0] HI = 29'h0000015; // unused upper row bits zero
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
    if (ca_done === 1'b1)
      dones = dones + 1;
  ddrf_slave i_dut
  (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .select_n(select_n),
    .bus_clock(bus_clock),
    .bus_clock_complement(bus_clock_complement),
    .dq_in(dq_in),
    .dq_out(dq_out),
    .dq_oe(dq_oe),
    .strobe_mask_lanes_in(strobe_mask_lanes_in),
    .strobe_mask_lanes_out(strobe_mask_lanes_out),
    .strobe_mask_lanes_oe(strobe_mask_lanes_oe),
    .zero_latency_write(zero_latency_write),
    .busy(busy),
    .is_read(is_read),
    .is_register_space(is_register_space),
    .is_linear(is_linear),
    .word_addr_hi(word_addr_hi),
    .start_word(start_word),
    .ca_done(ca_done),
    .framing_error(framing_error)
  );
  ddrf_host_model i_host
  (
    .dq_out(dq_out),
    .strobe_mask_lanes_out(strobe_mask_lanes_out),
    .select_n(select_n),
    .bus_clock(bus_clock),
    .bus_clock_complement(bus_clock_complement),
    .dq_in(dq_in),
    .strobe_mask_lanes_in(strobe_mask_lanes_in)
  );
  task cmp(input [47:0] got, input [47:0] exp);
  begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task dec(input [2:0] f, input [2:0] sw);
  begin
    cmp({is_read, is_register_space, is_linear}, f);
    cmp(word_addr_hi, HI);
    cmp(start_word, sw);
  end
  endtask
  task conclude;
  begin
    $display("tests=%0d errors=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  task t_bad_start;
  begin
    i_host.bad_start;
    repeat (4) @(posedge sys_clk);
    cmp(framing_error, 1);
    $display("bad start done");
  end
  endtask
  task t_zl_write;
    integer i;
  begin
    @(posedge sys_clk) zero_latency_write <= 1'b1;
    for (i = 0; i < 8; i = i + 1)
    begin
      i_host.wd[i] = 16'h1234 + 16'h1111 * i;
      i_host.wm[i] = 2'h3;
      mem[i] = i_host.wd[i];
    end
    // masks left high: they must be ignored here
    i_host.xact({3'b001, HI, 13'h0000, 3'h0}, 0, 8, 1'b0);
    @(posedge sys_clk) zero_latency_write <= 1'b0;
    cmp(framing_error, 0);
    dec(3'b001, 3'h0);
    $display("zero-latency write done");
  end
  endtask
  task t_mask_write;
    integer i;
  begin
    for (i = 0; i < 8; i = i + 1)
    begin
      i_host.wd[i] = 16'hc3c0 + i;
      i_host.wm[i] = i % 4;
      if (!i_host.wm[i][0])
        mem[(6+i)%8][7:0] = i_host.wd[i][7:0];
      if (!i_host.wm[i][1])
        mem[(6+i)%8][15:8] = i_host.wd[i][15:8];
    end
    i_host.xact({3'b000, HI, 13'h0000, 3'h6}, 8, 8, 1'b0);
    dec(3'b000, 3'h6);
    $display("masked write done");
  end
  endtask
  task t_read;
    integer i;
  begin
    i_host.xact({3'b100, HI, 13'h0000, 3'h3}, 8, 8, 1'b1);
    for (i = 0; i < 8; i = i + 1)
    begin
      cmp(i_host.rd[i], mem[(3+i)%8]);
      cmp(i_host.rs[i], (i % 2) ? 2'h0 : 2'h3);
    end
    dec(3'b100, 3'h3);
    i_host.xact({3'b110, HI, 13'h0000, 3'h0}, 8, 2, 1'b1);
    dec(3'b110, 3'h0);
    $display("reads done");
  end
  endtask
  initial
  begin
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_bad_start;
    t_zl_write;
    t_mask_write;
    t_read;
    cmp(dones, 4);
    conclude;
  end
  initial
  begin
    #50000;
    err_count = err_count + 1;
    conclude;
  end
endmodule // testbench
